/* hw/gpgh_consts.svh */
// register offsets, field positions and reset values of the two small ports
`ifndef GPGH_CONSTS_SVH
`define GPGH_CONSTS_SVH

// ****************************************************************
// register byte addresses on the register bus
// ****************************************************************
`define GPGH_ADDR_WIDTH     12
`define GPGH_OFF_THREE_DATA 12'h000
`define GPGH_OFF_TWO_DATA   12'h004
// the three-pin direction offset is not word aligned, so it is kept as a
// register index and the bus sees four times that index
`define GPGH_IDX_THREE_DIR  12'h00E
`define GPGH_OFF_THREE_DIR  12'h038
`define GPGH_OFF_TWO_DIR    12'h008

// ****************************************************************
// field widths, positions and reset values
// ****************************************************************
`define GPGH_THREE_PINS     3
`define GPGH_TWO_PINS       2
`define GPGH_KEYPAD_INTERRUPT_ENABLES_THREE_LSB 0
`define GPGH_KEYPAD_INTERRUPT_ENABLES_TWO_LSB   3
`define GPGH_KEYPAD_INTERRUPT_ENABLES_WIDTH     5
`define GPGH_THREE_DIR_RST  3'h0
`define GPGH_TWO_DIR_RST    2'h0

`endif

/* hw/gpgh_pkg.sv */
// types shared by the two-port general purpose block
package gpgh_pkg;

  // ****************************************************************
  // apb request bundle
  // ****************************************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } gpgh_apb_req_s;

  // ****************************************************************
  // apb answer bundle
  // ****************************************************************
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } gpgh_apb_rsp_s;

  // ****************************************************************
  // pad bundle for one five-pin group
  // ****************************************************************
  typedef struct packed {
    logic [4:0] pin_out;
    logic [4:0] pin_oe;
  } gpgh_pad_s;

endpackage

/* hw/gpgh_ports.sv */
// three-pin and two-pin general purpose ports with apb register access
//
// Summary of operation
// (R1) three-pin port keeps one data latch per pin in data bits 2 to 0.
// (R2) software reads and writes three-pin data, pin direction follows its bit.
// (R3) reset leaves the three-pin data latches as they were.
// (R4) a set keypad enable bit 2..0 makes that three-pin pin an input.
// (R5) a 1 in a three-pin direction bit drives the pin, a 0 makes it input.
// (R6) three-pin direction sits at index 000E, bits 2..0, upper bits read 0.
// (R7) the two-pin port is special function, both pins shared with keypad.
// (R8) two-pin port keeps one data latch per pin in data bits 1 and 0.
// (R9) software reads and writes two-pin data, pin direction follows its bit.
// (R10) reset leaves the two-pin data latches as they were.
// (R11) a set keypad enable bit 4 or 3 makes that two-pin pin an input.
// (R12) a 1 in a two-pin direction bit drives the pin, a 0 makes it input.
// (R13) reset clears both two-pin direction bits.
// (R14) software should load two-pin data before turning a pin to output.
// (R15) the three-pin port is special function, all pins shared with keypad.
// (R16) data reads return the latch for outputs and the pin level for inputs.
`timescale 1ns/100ps
`include "gpgh_consts.svh"

module gpgh_ports
(
  // clock, reset and freeze
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  // register bus
  input  wire gpgh_pkg::gpgh_apb_req_s apb_req,
  output gpgh_pkg::gpgh_apb_rsp_s    apb_rsp,
  // keypad enables from the keyboard interrupt block
  input  wire logic [4:0]            keypad_interrupt_enables,
  // pads: bits 2..0 three-pin port, bits 4..3 two-pin port
  input  wire logic [4:0]            pin_in,
  output gpgh_pkg::gpgh_pad_s        pad,
  // pin levels handed to the keyboard interrupt block
  output logic [4:0]                 keypad_wake_pins
);
  import gpgh_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [2:0]  three_pin_data_bits_reg;
  logic [2:0]  three_pin_direction_bits_reg;
  logic [1:0]  two_pin_data_bits_reg;
  logic [1:0]  two_pin_direction_bits_reg;
  logic [31:0] prdata_reg;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire logic        acc_setup;
  wire logic        wr_strobe;
  wire logic        hit_three_data;
  wire logic        hit_two_data;
  wire logic        hit_three_dir;
  wire logic        hit_two_dir;
  wire logic        hit_any;
  wire logic [4:0]  eff_dir;
  wire logic [4:0]  latch_all;
  wire logic [4:0]  readback;
  wire logic [31:0] rd_mux;

  // an address compare used for all four registers
  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] off);
    addr_is = (a == off);
  endfunction

  // zero-wait slave: every access completes in its first access cycle
  assign acc_setup      = apb_req.psel & ~apb_req.penable;
  assign wr_strobe      = apb_req.psel & apb_req.penable & apb_req.pwrite
                          & clk_en;
  assign hit_three_data = addr_is(apb_req.paddr, `GPGH_OFF_THREE_DATA);
  assign hit_two_data   = addr_is(apb_req.paddr, `GPGH_OFF_TWO_DATA);
  assign hit_three_dir  = addr_is(apb_req.paddr, `GPGH_OFF_THREE_DIR);
  assign hit_two_dir    = addr_is(apb_req.paddr, `GPGH_OFF_TWO_DIR);
  assign hit_any        = hit_three_data | hit_two_data | hit_three_dir
                          | hit_two_dir;

  // ****************************************************************
  // pin direction and drive
  // ****************************************************************
  // keypad enable forces the pin to input whatever its direction bit says
  assign eff_dir[2:0] = three_pin_direction_bits_reg
                        & ~keypad_interrupt_enables[2:0];  // see (R4) (R5) (R15)
  assign eff_dir[4:3] = two_pin_direction_bits_reg
                        & ~keypad_interrupt_enables[4:3];  // see (R11) (R12) (R7)
  assign latch_all    = {two_pin_data_bits_reg, three_pin_data_bits_reg};
  // one assignment for the whole bundle keeps a single driver on it
  assign pad = '{pin_out: latch_all,                       // see (R2) (R9)
                 pin_oe:  eff_dir};

  // all five pins always reach the keypad logic as plain levels
  assign keypad_wake_pins = pin_in;                        // see (R7) (R15)

  // outputs read back their latch, inputs read the pin
  assign readback = (eff_dir & latch_all) | (~eff_dir & pin_in); // see (R16)

  // ****************************************************************
  // read data selection
  // ****************************************************************
  assign rd_mux =
      hit_three_data ? {29'h0000000, readback[2:0]} :
      hit_two_data   ? {30'h0, readback[4:3]} :
      hit_three_dir  ? {29'h0, three_pin_direction_bits_reg} : // see (R6)
      hit_two_dir    ? {30'h0, two_pin_direction_bits_reg} :
                       32'h00000000;

  // zero wait: the slave never stretches an access
  assign apb_rsp = '{pready:  1'b1,
                     pslverr: apb_req.psel & apb_req.penable & ~hit_any,
                     prdata:  prdata_reg};

  // ****************************************************************
  // data latches: no reset, their content survives it
  // ****************************************************************
  // a reset value here would break the documented hold-through-reset
  always_ff @(posedge pclk)
  begin
    if (wr_strobe && hit_three_data)
      three_pin_data_bits_reg <= apb_req.pwdata[2:0];   // see (R1) (R2) (R3)
    if (wr_strobe && hit_two_data)
      two_pin_data_bits_reg <= apb_req.pwdata[1:0];     // see (R8) (R9) (R10)
  end

  // ****************************************************************
  // direction registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      three_pin_direction_bits_reg <= `GPGH_THREE_DIR_RST;
      two_pin_direction_bits_reg   <= `GPGH_TWO_DIR_RST;  // see (R13)
    end
    else if (wr_strobe)
    begin
      if (hit_three_dir)
        three_pin_direction_bits_reg <= apb_req.pwdata[2:0]; // see (R5) (R6)
      if (hit_two_dir)
        two_pin_direction_bits_reg <= apb_req.pwdata[1:0];   // see (R12)
    end
  end

  // ****************************************************************
  // read data register, loaded in setup so it stands in access
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h00000000;
    else if (clk_en && acc_setup && !apb_req.pwrite)
      prdata_reg <= rd_mux;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_keypad_interrupt_enables_override: assert property (   // see (R4)
    @(posedge pclk) disable iff (!presetn)
    keypad_interrupt_enables[2:0] != 3'h0 |->
      (pad.pin_oe[2:0] & keypad_interrupt_enables[2:0]) == 3'h0)
    else $error("keypad enable did not force three-pin input");

  chk_two_keypad_interrupt_enables: assert property (        // see (R11)
    @(posedge pclk) disable iff (!presetn)
    (pad.pin_oe[4:3] & keypad_interrupt_enables[4:3]) == 2'h0)
    else $error("keypad enable did not force two-pin input");

  chk_dir_write: assert property (       // see (R5)
    @(posedge pclk) disable iff (!presetn)
    wr_strobe && hit_three_dir |=>
      three_pin_direction_bits_reg == $past(apb_req.pwdata[2:0]))
    else $error("three-pin direction write lost");

  chk_two_dir_write: assert property (   // see (R12)
    @(posedge pclk) disable iff (!presetn)
    wr_strobe && hit_two_dir |=>
      two_pin_direction_bits_reg == $past(apb_req.pwdata[1:0]))
    else $error("two-pin direction write lost");

  chk_three_data: assert property (      // see (R1)
    @(posedge pclk) disable iff (!presetn)
    wr_strobe && hit_three_data |=>
      pad.pin_out[2:0] == $past(apb_req.pwdata[2:0]))
    else $error("three-pin latch not driven to pad");

  chk_two_data: assert property (        // see (R8)
    @(posedge pclk) disable iff (!presetn)
    wr_strobe && hit_two_data |=>
      pad.pin_out[4:3] == $past(apb_req.pwdata[1:0]))
    else $error("two-pin latch not driven to pad");

  chk_dir_upper: assert property (       // see (R6)
    @(posedge pclk) disable iff (!presetn)
    clk_en && acc_setup && !apb_req.pwrite && hit_three_dir |=>
      prdata_reg[31:3] == 29'h0000000)
    else $error("three-pin direction upper bits not zero");

  chk_read_mix: assert property (        // see (R16)
    @(posedge pclk) disable iff (!presetn)
    clk_en && acc_setup && !apb_req.pwrite && hit_three_data |=>
      prdata_reg[2:0] == $past(readback[2:0]))
    else $error("three-pin data readback wrong");

  // ****************************************************************
  // check helpers
  // ****************************************************************
  // latches hold no reset value, so a hold check only makes sense once
  // software has loaded them; before that they are unknown
  logic three_written_reg;
  logic two_written_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      three_written_reg <= 1'b0;
      two_written_reg   <= 1'b0;
    end
    else
    begin
      if (wr_strobe && hit_three_data)
        three_written_reg <= 1'b1;
      if (wr_strobe && hit_two_data)
        two_written_reg <= 1'b1;
    end
  end

  chk_latch_hold: assert property (      // see (R2)
    @(posedge pclk) disable iff (!presetn)
    three_written_reg && !(wr_strobe && hit_three_data) |=>
      $stable(three_pin_data_bits_reg))
    else $error("three-pin latch changed without a write");

  chk_two_hold: assert property (        // see (R9)
    @(posedge pclk) disable iff (!presetn)
    two_written_reg && !(wr_strobe && hit_two_data) |=>
      $stable(two_pin_data_bits_reg))
    else $error("two-pin latch changed without a write");

  // a frozen clock enable must leave every register alone
  chk_frozen_dir: assert property (
    @(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(three_pin_direction_bits_reg)
                && $stable(two_pin_direction_bits_reg))
    else $error("direction changed while frozen");

  chk_frozen_rd: assert property (
    @(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(prdata_reg))
    else $error("read data changed while frozen");

  chk_pready_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_rsp.pready == 1'b1)
    else $error("slave inserted a wait state");

  chk_two_read: assert property (        // see (R16)
    @(posedge pclk) disable iff (!presetn)
    clk_en && acc_setup && !apb_req.pwrite && hit_two_data |=>
      prdata_reg == {30'h0, $past(readback[4:3])})
    else $error("two-pin data readback wrong");

  chk_two_dir_read: assert property (    // see (R9)
    @(posedge pclk) disable iff (!presetn)
    clk_en && acc_setup && !apb_req.pwrite && hit_two_dir |=>
      prdata_reg == {30'h0, $past(two_pin_direction_bits_reg)})
    else $error("two-pin direction readback wrong");

  // an unmapped read must not leak any register into the bus
  chk_unmapped_rd: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && acc_setup && !apb_req.pwrite && !hit_any |=>
      prdata_reg == 32'h00000000)
    else $error("unmapped read returned data");

  // no pin may drive unless its direction bit asks for it
  chk_drive_dir: assert property (       // see (R5) (R12)
    @(posedge pclk) disable iff (!presetn)
    (pad.pin_oe & ~{two_pin_direction_bits_reg,
                    three_pin_direction_bits_reg}) == 5'h00)
    else $error("pin driven with its direction bit clear");

  chk_wake_level: assert property (      // see (R7) (R15)
    @(posedge pclk) disable iff (!presetn)
    keypad_wake_pins == pin_in)
    else $error("keypad logic does not see the pad level");

endmodule

/* verification/gpgh_pin_partner.sv */
// model of the board circuitry wired to the five port pins
`timescale 1ns/100ps

// ****************************************************************
// pin partner
// ****************************************************************
module gpgh_pin_partner
(
  // clock
  input  wire logic       pclk,
  // chip side of the pads
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  // board drivers
  input  wire logic [4:0] ext_val,
  input  wire logic [4:0] ext_oe,
  // level seen at the pads
  output logic [4:0]      pin_in
);
  // undriven lines toggle so a stale level never reads back as valid
  logic [4:0] float_reg = 5'h15;
  always_ff @(posedge pclk)
    float_reg <= ~float_reg;
  // chip driver wins over the board; contention is not modelled
  assign pin_in = (pin_out & pin_oe) | (ext_val & ext_oe & ~pin_oe)
                | (float_reg & ~pin_oe & ~ext_oe);
endmodule

/* verification/gpgh_ports_g_h_tb_top.sv */
// self-checking bench for the three-pin and two-pin ports
`timescale 1ns/100ps
`include "gpgh_consts.svh"

// ****************************************************************
// bench top
// ****************************************************************
module gpgh_ports_g_h_tb_top;
  import gpgh_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  gpgh_apb_req_s req = '0;
  gpgh_apb_rsp_s rsp;
  logic [4:0] kbe = 5'h00;
  logic [4:0] ext_val = 5'h00;
  logic [4:0] ext_oe = 5'h1F;
  logic [4:0] pin_in;
  gpgh_pad_s pad;
  logic [4:0] wake;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] rd, d3, d2, r3, r2;
  logic [4:0] oe;
  logic [4:0] e5;
  logic err;

  always #10 pclk = ~pclk;

  gpgh_ports dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .apb_req(req), .apb_rsp(rsp), .keypad_interrupt_enables(kbe),
    .pin_in(pin_in), .pad(pad), .keypad_wake_pins(wake));
  gpgh_pin_partner brd (.pclk(pclk), .pin_out(pad.pin_out),
    .pin_oe(pad.pin_oe), .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));

  // one apb transfer; request held until pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      $display("CHECK FAILED apb_wait expected %h seen %h", 1'b1, rsp.pready);
      bad_count++;
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  // latch for effective outputs, pad level for inputs
  function automatic logic [4:0] exp_rd(logic [4:0] lat, logic [4:0] e,
                                        logic [4:0] lvl);
    return (lat & e) | (lvl & ~e);
  endfunction

  task tally_and_finish;
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog sized well above the roughly six hundred cycles the tests need
  initial
  begin
    #400000;
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(32'h42e560ce));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `GPGH_OFF_TWO_DIR, 32'h0);
    chk("two_dir_rst", 32'h0, rd);
    apb(1'b0, `GPGH_OFF_THREE_DIR, 32'h0);
    chk("three_dir_rst", 32'h0, rd);
    for (int i = 0; i < 24; i++)
    begin
      d3 = $urandom;
      d2 = $urandom;
      r3 = (i < 2) ? 32'hFFFFFFFF : $urandom;
      r2 = (i < 2) ? 32'hFFFFFFFF : $urandom;
      // data loaded before direction to keep outputs clean
      apb(1'b1, `GPGH_OFF_THREE_DATA, d3);
      apb(1'b1, `GPGH_OFF_TWO_DATA, d2);
      apb(1'b1, `GPGH_OFF_THREE_DIR, r3);
      apb(1'b1, `GPGH_OFF_TWO_DIR, r2);
      kbe <= (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : 5'($urandom);
      ext_val <= 5'($urandom);
      apb(1'b0, `GPGH_OFF_THREE_DIR, 32'h0);
      chk("three_dir", {29'h0, r3[2:0]}, rd);
      apb(1'b0, `GPGH_OFF_TWO_DIR, 32'h0);
      chk("two_dir", {30'h0, r2[1:0]}, rd);
      oe = {r2[1:0], r3[2:0]} & ~kbe;
      @(negedge pclk);
      chk("pin_out", {27'h0, d2[1:0], d3[2:0]}, {27'h0, pad.pin_out});
      chk("pin_oe", {27'h0, oe}, {27'h0, pad.pin_oe});
      chk("wake", {27'h0, pin_in}, {27'h0, wake});
      e5 = exp_rd({d2[1:0], d3[2:0]}, oe, ext_val);
      apb(1'b0, `GPGH_OFF_THREE_DATA, 32'h0);
      chk("three_rd", {29'h0, e5[2:0]}, rd);
      apb(1'b0, `GPGH_OFF_TWO_DATA, 32'h0);
      chk("two_rd", {30'h0, e5[4:3]}, rd);
    end
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_rd", 32'h0, rd);
    chk("unmapped_err", 32'h1, {31'h0, err});
    // frozen clock enable must drop the write
    @(posedge pclk);
    clk_en <= 1'b0;
    apb(1'b1, `GPGH_OFF_THREE_DATA, ~d3);
    clk_en <= 1'b1;
    @(negedge pclk);
    chk("frozen_wr", {29'h0, d3[2:0]}, {29'h0, pad.pin_out[2:0]});
    // second reset keeps latches, clears directions
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("latch_keep", {27'h0, d2[1:0], d3[2:0]}, {27'h0, pad.pin_out});
    chk("oe_rst", 32'h0, {27'h0, pad.pin_oe});
    apb(1'b0, `GPGH_OFF_TWO_DIR, 32'h0);
    chk("two_dir_rst2", 32'h0, rd);
    tally_and_finish();
  end
endmodule
